// [verilog/i2so_regs.svh]
// Constants of the two-wire slave front end: codes, reset values, timing.
// Assumes a single 100 MHz clock; included by name wherever needed.
`ifndef I2SO_REGS_SVH
`define I2SO_REGS_SVH

`define I2SO_GROUP_CODE   4'hc
`define I2SO_SUB_LOAD     8'h11
`define I2SO_SUB_COPY     8'h22
`define I2SO_SUB_BOTH     8'h44
`define I2SO_REG_RESET    8'h00
`define I2SO_BYTE_BITS    4'h8
`define I2SO_CLOCK_NS     10
`define I2SO_FILTER_NS    30
`define I2SO_FILTER_LEN   ((`I2SO_FILTER_NS + `I2SO_CLOCK_NS - 1) / `I2SO_CLOCK_NS)
`define I2SO_FIFO_WIDTH   10
`define I2SO_FIFO_DEPTH   4

`endif

// [verilog/i2so_pkg.sv]
// Types of the two-wire slave front end.
// Assumes nothing of its surroundings.
package i2so_pkg;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_SUB,
        ST_SUB_ACK,
        ST_DATA,
        ST_DATA_ACK,
        ST_READ,
        ST_READ_ACK,
        ST_DONE
    } i2so_state_type;
endpackage

// [verilog/i2so_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
module i2so_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    assign inReady  = (count != FULL);
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + PW'(1);
            end
            if (pop) begin
                rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + PW'(1);
            end
            if (push && !pop) begin
                count <= count + CW'(1);
            end else if (pop && !push) begin
                count <= count - CW'(1);
            end
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clock) disable iff (reset)
        count <= FULL) else $error("FIFO count above depth");
endmodule // i2so_fifo

// [verilog/i2so_top.sv]
// Two-wire serial slave front end feeding an 8-bit shift and output storage register.
// Assumes bus pins arrive asynchronously and an external pullup on the data wire.
`include "i2so_regs.svh"

module i2so_top (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Bus pins
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // Address select pins
    input  wire logic [2:0] addrSelect,
    // Register update stall
    input  wire logic       applyHold,
    // Register contents
    output logic      [7:0] shiftData,
    output logic      [7:0] outputData
);
    localparam int FL = `I2SO_FILTER_LEN;

    i2so_pkg::i2so_state_type state;
    logic [1:0]    sync1;
    logic [1:0]    sync2;
    logic [2:0]    addrSync1;
    logic [2:0]    addrSync2;
    logic [FL-1:0] sclHist;
    logic [FL-1:0] sdaHist;
    logic          sclF;
    logic          sdaF;
    logic          sclPrev;
    logic          sdaPrev;
    logic          sclRise;
    logic          sclFall;
    logic          startCond;
    logic          stopCond;
    logic          receiving;
    logic          addrMatch;
    logic          subKnown;
    logic [3:0]    bitCount;
    logic [7:0]    shiftIn;
    logic [7:0]    subAddr;
    logic [7:0]    txShift;
    logic          rw;
    logic          pushValid;
    logic [9:0]    pushData;
    logic          fifoInReady;
    logic          popValid;
    logic [9:0]    popData;
    logic          popFire;

    // Synchroniser then glitch filter on clock and data
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1     <= 2'h3;
            sync2     <= 2'h3;
            addrSync1 <= 3'h0;
            addrSync2 <= 3'h0;
            sclHist   <= '1;
            sdaHist   <= '1;
            sclF      <= 1'b1;
            sdaF      <= 1'b1;
            sclPrev   <= 1'b1;
            sdaPrev   <= 1'b1;
        end else begin
            sync1     <= {sclIn, sdaIn};
            sync2     <= sync1;
            addrSync1 <= addrSelect;
            addrSync2 <= addrSync1;
            sclHist   <= {sclHist[FL-2:0], sync2[1]};
            sdaHist   <= {sdaHist[FL-2:0], sync2[0]};
            // A level is taken only once it has held for the whole window
            if (&sclHist) sclF <= 1'b1;
            else if (~|sclHist) sclF <= 1'b0;
            if (&sdaHist) sdaF <= 1'b1;
            else if (~|sdaHist) sdaF <= 1'b0;
            sclPrev   <= sclF;
            sdaPrev   <= sdaF;
        end
    end

    assign sclRise   = sclF && !sclPrev;
    assign sclFall   = !sclF && sclPrev;
    assign startCond = sclF && sclPrev && sdaPrev && !sdaF;
    assign stopCond  = sclF && sclPrev && !sdaPrev && sdaF;
    assign receiving = (state == i2so_pkg::ST_ADDR) || (state == i2so_pkg::ST_SUB)
                       || (state == i2so_pkg::ST_DATA);
    assign addrMatch = (shiftIn[7:4] == `I2SO_GROUP_CODE)
                       && (shiftIn[3:1] == addrSync2);
    assign subKnown  = (shiftIn == `I2SO_SUB_LOAD) || (shiftIn == `I2SO_SUB_COPY)
                       || (shiftIn == `I2SO_SUB_BOTH);

    // Open drain: the driven level is always low
    always_ff @(posedge clock or posedge reset) begin
        if (reset) sdaOut <= 1'b0;
        else sdaOut <= 1'b0;
    end

    // Bus state machine; drive changes follow a filtered clock fall, a start or a stop
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state     <= i2so_pkg::ST_IDLE;
            bitCount  <= 4'h0;
            shiftIn   <= 8'h00;
            subAddr   <= 8'h00;
            txShift   <= 8'h00;
            rw        <= 1'b0;
            sdaOe     <= 1'b0;
            pushValid <= 1'b0;
            pushData  <= 10'h000;
        end else begin
            pushValid <= 1'b0;
            if (startCond) begin
                state    <= i2so_pkg::ST_ADDR;
                bitCount <= 4'h0;
                sdaOe    <= 1'b0;
            end else if (stopCond) begin
                state <= i2so_pkg::ST_IDLE;
                sdaOe <= 1'b0;
            end else begin
                if (sclRise && receiving) begin
                    shiftIn  <= {shiftIn[6:0], sdaF};
                    bitCount <= bitCount + 4'h1;
                end
                if (sclFall) begin
                    case (state)
                        i2so_pkg::ST_ADDR: begin
                            if (bitCount == `I2SO_BYTE_BITS) begin
                                bitCount <= 4'h0;
                                if (addrMatch) begin
                                    rw    <= shiftIn[0];
                                    sdaOe <= 1'b1;
                                    state <= i2so_pkg::ST_ADDR_ACK;
                                end else begin
                                    state <= i2so_pkg::ST_DONE;
                                end
                            end
                        end
                        i2so_pkg::ST_ADDR_ACK: begin
                            sdaOe <= 1'b0;
                            state <= i2so_pkg::ST_SUB;
                        end
                        i2so_pkg::ST_SUB: begin
                            if (bitCount == `I2SO_BYTE_BITS) begin
                                bitCount <= 4'h0;
                                subAddr  <= shiftIn;
                                // Full buffer withholds the ack rather than lose a copy
                                if (subKnown && (shiftIn != `I2SO_SUB_COPY || fifoInReady)) begin
                                    sdaOe <= 1'b1;
                                    state <= i2so_pkg::ST_SUB_ACK;
                                    if (shiftIn == `I2SO_SUB_COPY) begin
                                        pushValid <= 1'b1;
                                        pushData  <= {2'h2, 8'h00};
                                    end
                                end else begin
                                    state <= i2so_pkg::ST_DONE;
                                end
                            end
                        end
                        i2so_pkg::ST_SUB_ACK: begin
                            if (subAddr == `I2SO_SUB_COPY) begin
                                sdaOe <= 1'b0;
                                state <= i2so_pkg::ST_DONE;
                            end else if (subAddr == `I2SO_SUB_LOAD && rw) begin
                                sdaOe    <= ~shiftData[7];
                                txShift  <= {shiftData[6:0], 1'b0};
                                bitCount <= 4'h1;
                                state    <= i2so_pkg::ST_READ;
                            end else begin
                                sdaOe <= 1'b0;
                                state <= i2so_pkg::ST_DATA;
                            end
                        end
                        i2so_pkg::ST_DATA: begin
                            if (bitCount == `I2SO_BYTE_BITS) begin
                                bitCount <= 4'h0;
                                if (!rw && fifoInReady) begin
                                    sdaOe     <= 1'b1;
                                    pushValid <= 1'b1;
                                    pushData  <= {(subAddr == `I2SO_SUB_BOTH), 1'b1, shiftIn};
                                    state     <= i2so_pkg::ST_DATA_ACK;
                                end else begin
                                    state <= i2so_pkg::ST_DONE;
                                end
                            end
                        end
                        i2so_pkg::ST_DATA_ACK: begin
                            sdaOe <= 1'b0;
                            state <= i2so_pkg::ST_DONE;
                        end
                        i2so_pkg::ST_READ: begin
                            if (bitCount == `I2SO_BYTE_BITS) begin
                                sdaOe <= 1'b0;
                                state <= i2so_pkg::ST_READ_ACK;
                            end else begin
                                sdaOe    <= ~txShift[7];
                                txShift  <= {txShift[6:0], 1'b0};
                                bitCount <= bitCount + 4'h1;
                            end
                        end
                        i2so_pkg::ST_READ_ACK: begin
                            state <= i2so_pkg::ST_DONE;
                        end
                        default: begin
                            state <= state;
                        end
                    endcase
                end
            end
        end
    end

    i2so_fifo #(
        .WIDTH (`I2SO_FIFO_WIDTH),
        .DEPTH (`I2SO_FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .reset    (reset),
        .inValid  (pushValid),
        .inReady  (fifoInReady),
        .inData   (pushData),
        .outValid (popValid),
        .outReady (!applyHold),
        .outData  (popData)
    );

    assign popFire = popValid && !applyHold;

    // Command entry: bit 9 copy to storage, bit 8 load shift, bits 7:0 data
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            shiftData  <= `I2SO_REG_RESET;
            outputData <= `I2SO_REG_RESET;
        end else if (popFire) begin
            if (popData[8]) shiftData <= popData[7:0];
            if (popData[9]) outputData <= popData[8] ? popData[7:0] : shiftData;
        end
    end

    a_start_to_addr: assert property (@(posedge clock) disable iff (reset)
        startCond |=> (state == i2so_pkg::ST_ADDR) && (bitCount == 4'h0) && !sdaOe)
        else $error("Start not followed by address reception");
    a_stop_to_idle: assert property (@(posedge clock) disable iff (reset)
        stopCond && !startCond |=> (state == i2so_pkg::ST_IDLE) && !sdaOe)
        else $error("Stop did not return to idle");
    a_group_mismatch: assert property (@(posedge clock) disable iff (reset)
        (state == i2so_pkg::ST_ADDR) && sclFall && !startCond && !stopCond
        && (bitCount == 4'h8) && (shiftIn[7:4] != 4'hc)
        |=> (state == i2so_pkg::ST_DONE) && !sdaOe ##1 !sdaOe)
        else $error("Wrong group code was answered");
    a_addr_ack: assert property (@(posedge clock) disable iff (reset)
        (state == i2so_pkg::ST_ADDR) && sclFall && !startCond && !stopCond
        && (bitCount == 4'h8) && (shiftIn[7:4] == 4'hc) && (shiftIn[3:1] == addrSync2)
        |=> sdaOe && (state == i2so_pkg::ST_ADDR_ACK))
        else $error("Matching address not acknowledged");
    a_open_drain: assert property (@(posedge clock) disable iff (reset)
        sdaOe |-> !sdaOut && (state inside {i2so_pkg::ST_ADDR_ACK, i2so_pkg::ST_SUB_ACK,
            i2so_pkg::ST_DATA_ACK, i2so_pkg::ST_READ})) else $error("Data line driven high");
    a_push_taken: assert property (@(posedge clock) disable iff (reset)
        pushValid |-> fifoInReady) else $error("Acknowledged command lost");
    a_drive_clock_low: assert property (@(posedge clock) disable iff (reset)
        !$stable(sdaOe) |-> !sclF || $past(stopCond) || $past(startCond))
        else $error("Data drive changed while clock high");
    a_undefined_sub: assert property (@(posedge clock) disable iff (reset)
        (state == i2so_pkg::ST_SUB) && sclFall && !startCond && !stopCond
        && (bitCount == 4'h8) && !subKnown
        |=> (state == i2so_pkg::ST_DONE) && !sdaOe && !pushValid)
        else $error("Undefined subaddress was answered");
    a_transfer_done: assert property (@(posedge clock) disable iff (reset)
        (state == i2so_pkg::ST_DATA_ACK) && sclFall && !startCond && !stopCond
        |=> (state == i2so_pkg::ST_DONE) && !sdaOe)
        else $error("Transfer not finished after data byte");
    a_load_only: assert property (@(posedge clock) disable iff (reset)
        popFire && popData[8] && !popData[9]
        |=> (shiftData == $past(popData[7:0])) && $stable(outputData))
        else $error("Load touched output storage");
    a_load_copy: assert property (@(posedge clock) disable iff (reset)
        popFire && popData[8] && popData[9]
        |=> (outputData == $past(popData[7:0])) && (shiftData == outputData))
        else $error("Load and copy mismatch");
    a_copy_only: assert property (@(posedge clock) disable iff (reset)
        popFire && !popData[8] && popData[9]
        |=> (outputData == $past(shiftData)) && $stable(shiftData))
        else $error("Copy did not take shift contents");
endmodule // i2so_top

// [bench/i2so_master.sv]
// Behavioural bus controller: makes the clock, drives data open-drain.
// Assumes the bench resolves the data wire with a pullup and returns it.
module i2so_master (
    // Clock
    input  wire logic clock,
    // Bus
    input  wire logic sdaWire,
    output logic      scl,
    output logic      sdaLow
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quarter bit in clocks; raise it for a slow controller
    int quarter = 10;

    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Repeated start first returns both lines high
    task automatic sendStart();
        if (scl == 1'b0) begin
            sdaLow = 1'b0;
            pause(quarter);
            scl = 1'b1;
            pause(quarter);
        end
        sdaLow = 1'b1;
        pause(quarter);
        scl = 1'b0;
        pause(quarter);
    endtask

    task automatic sendStop();
        sdaLow = 1'b1;
        pause(quarter);
        scl = 1'b1;
        pause(quarter);
        sdaLow = 1'b0;
        pause(2 * quarter);
    endtask

    task automatic sendBit(input logic b);
        sdaLow = ~b;
        pause(quarter);
        scl = 1'b1;
        pause(2 * quarter);
        scl = 1'b0;
        pause(quarter);
    endtask

    // Sampled mid-high, long after the device's filter delay
    task automatic getBit(output logic b);
        sdaLow = 1'b0;
        pause(quarter);
        scl = 1'b1;
        pause(quarter);
        b = sdaWire;
        pause(quarter);
        scl = 1'b0;
        pause(quarter);
    endtask

    // Short clock pulse the device must filter out
    task automatic glitchScl(input int n);
        scl = ~scl;
        pause(n);
        scl = ~scl;
        pause(quarter);
    endtask

    task automatic writeByte(input logic [7:0] value, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sendBit(value[i]);
        end
        getBit(ack);
    endtask

    task automatic readByte(output logic [7:0] value);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            getBit(b);
            value[i] = b;
        end
        sendBit(1'b1);
    endtask
endmodule // i2so_master

// [bench/i2so_top_bench.sv]
// Self-checking bench for the two-wire slave front end.
// Assumes the controller model and a pullup on the data wire.
`include "i2so_regs.svh"
module i2so_top_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clock;
    logic       reset;
    logic [2:0] addrSelect;
    logic       applyHold;
    logic       sdaOut;
    logic       sdaOe;
    logic [7:0] shiftData;
    logic [7:0] outputData;
    logic       scl;
    logic       sdaLow;
    logic       sdaWire;
    int         fails = 0;
    int         samplesChecked = 0;

    // Pullup: low only while someone pulls
    assign sdaWire = (sdaOe === 1'b1 || sdaLow === 1'b1) ? 1'b0 : 1'b1;

    i2so_top i_dut (.clock(clock), .reset(reset), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelect(addrSelect), .applyHold(applyHold),
        .shiftData(shiftData), .outputData(outputData));
    i2so_master i_master (.clock(clock), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic checkBit(input logic got, input logic exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic checkRegs(input logic [7:0] s, input logic [7:0] o);
        checkByte(shiftData, s, "shift register");
        checkByte(outputData, o, "output register");
    endtask

    function automatic logic [7:0] addrOf(input logic [2:0] sel, input logic rw);
        return {`I2SO_GROUP_CODE, sel, rw};
    endfunction

    // expNack bits: address, subaddress, data; 1 means released line
    task automatic xfer(input logic [7:0] adr, input logic [7:0] sub, input logic [7:0] data,
                        input logic [2:0] expNack);
        logic ack;
        i_master.sendStart();
        i_master.writeByte(adr, ack);
        checkBit(ack, expNack[2], "address ack");
        checkBit(sdaOut, 1'b0, "drive level");
        i_master.writeByte(sub, ack);
        checkBit(ack, expNack[1], "subaddress ack");
        i_master.writeByte(data, ack);
        checkBit(ack, expNack[0], "data ack");
        i_master.sendStop();
    endtask

    task automatic testCommands();
        checkRegs(8'h00, 8'h00);
        xfer(addrOf(3'h5, 1'b0), `I2SO_SUB_LOAD, 8'ha5, 3'b000);
        checkRegs(8'ha5, 8'h00);
        xfer(addrOf(3'h5, 1'b0), `I2SO_SUB_COPY, 8'h3c, 3'b001);
        checkRegs(8'ha5, 8'ha5);
        xfer(addrOf(3'h5, 1'b0), `I2SO_SUB_BOTH, 8'h5a, 3'b000);
        checkRegs(8'h5a, 8'h5a);
        xfer(addrOf(3'h5, 1'b1), `I2SO_SUB_BOTH, 8'hc3, 3'b001);
        checkRegs(8'h5a, 8'h5a);
    endtask

    // Slow controller reads the shift register back
    task automatic testRead();
        logic       ack;
        logic [7:0] v;
        i_master.quarter = 25;
        i_master.sendStart();
        i_master.writeByte(addrOf(3'h5, 1'b1), ack);
        checkBit(ack, 1'b0, "read address ack");
        i_master.writeByte(`I2SO_SUB_LOAD, ack);
        checkBit(ack, 1'b0, "read subaddress ack");
        i_master.readByte(v);
        i_master.sendStop();
        i_master.quarter = 10;
        checkByte(v, 8'h5a, "read data");
    endtask

    task automatic testAddress();
        logic [3:0] groups [5] = '{4'h0, 4'h4, 4'h8, 4'hd, 4'he};
        foreach (groups[i]) begin
            xfer({groups[i], 3'h5, 1'b0}, `I2SO_SUB_LOAD, 8'hff, 3'b111);
        end
        for (int s = 0; s < 8; s++) begin
            addrSelect = s[2:0];
            cycles(4);
            xfer(addrOf(s[2:0] ^ 3'h1, 1'b0), `I2SO_SUB_LOAD, 8'hff, 3'b111);
            xfer(addrOf(s[2:0], 1'b0), `I2SO_SUB_LOAD, 8'h10 + 8'(s), 3'b000);
            checkRegs(8'h10 + 8'(s), 8'h5a);
        end
        addrSelect = 3'h5;
        cycles(4);
    endtask

    task automatic testUndefined();
        logic [7:0] subs [6] = '{8'h00, 8'h12, 8'h21, 8'h33, 8'h88, 8'hff};
        foreach (subs[i]) begin
            xfer(addrOf(3'h5, 1'b0), subs[i], 8'h99, 3'b011);
        end
        checkRegs(8'h17, 8'h5a);
    endtask

    // Held queue fills; later commands refused, then drained in order
    task automatic testHold();
        applyHold = 1'b1;
        for (int k = 0; k < 4; k++) begin
            xfer(addrOf(3'h5, 1'b0), `I2SO_SUB_LOAD, 8'h60 + 8'(k), 3'b000);
        end
        xfer(addrOf(3'h5, 1'b0), `I2SO_SUB_LOAD, 8'h6f, 3'b001);
        xfer(addrOf(3'h5, 1'b0), `I2SO_SUB_COPY, 8'h00, 3'b011);
        checkRegs(8'h17, 8'h5a);
        applyHold = 1'b0;
        cycles(8);
        checkRegs(8'h63, 8'h5a);
    endtask

    task automatic testRestart();
        logic ack;
        i_master.sendStart();
        i_master.writeByte(addrOf(3'h5, 1'b0), ack);
        i_master.sendStart();
        i_master.writeByte(addrOf(3'h5, 1'b0), ack);
        checkBit(ack, 1'b0, "restart address ack");
        i_master.writeByte(`I2SO_SUB_LOAD, ack);
        i_master.writeByte(8'h42, ack);
        checkBit(ack, 1'b0, "restart data ack");
        i_master.writeByte(8'h24, ack);
        checkBit(ack, 1'b1, "byte after data");
        i_master.sendStop();
        checkRegs(8'h42, 8'h5a);
    endtask

    // A 20 ns clock spike before the data byte must not shift a bit in
    task automatic testGlitch();
        logic ack;
        i_master.sendStart();
        i_master.writeByte(addrOf(3'h5, 1'b0), ack);
        i_master.writeByte(`I2SO_SUB_LOAD, ack);
        i_master.glitchScl(2);
        i_master.writeByte(8'h96, ack);
        checkBit(ack, 1'b0, "data ack after glitch");
        i_master.sendStop();
        checkRegs(8'h96, 8'h5a);
    endtask

    task automatic testMidReset();
        logic [7:0] adr;
        adr = addrOf(3'h5, 1'b0);
        i_master.sendStart();
        for (int i = 7; i >= 0; i--) begin
            i_master.sendBit(adr[i]);
        end
        checkBit(sdaOe, 1'b1, "ack drive");
        reset = 1'b1;
        cycles(1);
        checkBit(sdaOe, 1'b0, "drive in reset");
        checkRegs(8'h00, 8'h00);
        reset = 1'b0;
        i_master.sendStop();
        cycles(4);
        xfer(adr, `I2SO_SUB_BOTH, 8'h81, 3'b000);
        checkRegs(8'h81, 8'h81);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // About 40 transfers of some 1100 clocks each
    initial begin
        #900us;
        fails++;
        conclude();
    end

    initial begin
        reset = 1'b1;
        addrSelect = 3'h5;
        applyHold = 1'b0;
        repeat (16) @(posedge clock);
        #1;
        reset = 1'b0;
        cycles(8);
        testCommands();
        testRead();
        testAddress();
        testUndefined();
        testHold();
        testRestart();
        testGlitch();
        testMidReset();
        conclude();
    end
endmodule // i2so_top_bench
